/* File: shared/bepr_regs.svh */
// Byte codes, sizes and counts of the boot erase and protect handler
`ifndef BEPR_REGS_SVH
`define BEPR_REGS_SVH
// Operation command codes
`define BEPR_OP_ERASE 8'h40
`define BEPR_OP_PROT 8'h60
// Erase sequence codes
`define BEPR_ERASE_KEY 8'h54
`define BEPR_ERASE_OK 8'h4F
`define BEPR_ERASE_BAD 8'h4C
`define BEPR_ERASE_OK_CNF 8'h5D
`define BEPR_ERASE_BAD_CNF 8'h60
// Protect sequence codes
`define BEPR_PROT_RXERR 8'h68
`define BEPR_PROT_CHKERR 8'h61
`define BEPR_PROT_ACCEPT 8'h60
`define BEPR_PROT_OK 8'h6F
`define BEPR_PROT_BAD 8'h6C
`define BEPR_PROT_OK_CNF 8'h31
`define BEPR_PROT_BAD_CNF 8'h34
// Low nibbles of error answers
`define BEPR_NIB_RXERR 4'h8
`define BEPR_NIB_CMDERR 4'h1
// Password area layout: 12 password bytes then 3 reset vector bytes
`define BEPR_PW_LEN 4'hC
`define BEPR_PW_LAST 4'hB
`define BEPR_AREA_LEN 4'hF
`define BEPR_SCAN_END 4'hF
`define BEPR_BLANK 8'hFF
`define BEPR_ZERO8 8'h00
`define BEPR_ZERO4 4'h0
`define BEPR_ONE4 4'h1
`endif

/* File: shared/bepr_pkg.sv */
// Types shared by the boot erase and protect handler
package bepr_pkg;
  // One received serial character and its error flag
  typedef struct packed {
    logic err;
    logic [7:0] data;
  } bepr_rx_s;
  // Completion report of the flash engine
  typedef struct packed {
    logic done;
    logic fail;
  } bepr_res_s;
  // Sequence states, one-hot
  typedef enum logic [8:0] {
    ST_CMD   = 9'h001,
    ST_ERKEY = 9'h002,
    ST_ERRUN = 9'h004,
    ST_PSCAN = 9'h008,
    ST_PWD   = 9'h010,
    ST_PCMP  = 9'h020,
    ST_PSUM  = 9'h040,
    ST_PRRUN = 9'h080,
    ST_TX    = 9'h100
  } bepr_state_e;
endpackage

/* File: core/bepr_pwd_mem.sv */
// Mirror of the password and reset vector area with registered read
module bepr_pwd_mem #(
  parameter int DEPTH = 15,
  parameter int AW = 4
) (
  // Clock
  input wire logic CLK,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem_reg [DEPTH]; // Storage
  logic [7:0] rdata_reg; // Read data flop

  ////////////////////////////////////////////////////////////////////////////
  // Write and registered read
  always_ff @(posedge CLK) begin
    if (we && (int'(waddr) < DEPTH)) begin
      mem_reg[waddr] <= wdata;
    end
    rdata_reg <= (int'(raddr) < DEPTH) ? mem_reg[raddr] : 8'hFF;
  end

  assign rdata = rdata_reg;
endmodule // bepr_pwd_mem

/* File: core/bepr_handler.sv */
// Byte-serial handler of the chip erase tail and the protect set command
`include "bepr_regs.svh"

// How it works
// - Faulty fifth byte answers x8, back to command
// - Error answers carry last command's upper nibble
// - Good enable byte echoed, then erase starts
// - Wrong clean fifth byte answers x1
// - Seventh byte: 4F pass, 4C fail
// - Eighth byte: 5D pass, 60 fail
// - Ninth byte is a new command
// - Third byte: x8 error, 60 echo, x1 unknown
// - Bytes five to sixteen compared to area
// - Receive error in 5..17 answers 68
// - Nonzero sum of 5..17 answers 61
// - Password mismatch answers 61
// - Error, then sum, then password; else 60
// - Nineteenth byte: 6F pass, 6C fail
// - Twentieth byte: 31 pass, 34 fail
// - Uniform password is error unless blank part
// - Twenty-first byte is a new command
module bepr_handler import bepr_pkg::*; (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Received bytes
  input wire logic RX_VALID,
  input wire bepr_rx_s RX_BYTE,
  output logic RX_READY,
  // Bytes to send
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  input wire logic TX_READY,
  // Flash erase engine
  output logic ERASE_REQ,
  input wire bepr_res_s ERASE_RES,
  // Flash protect engine
  output logic PROT_REQ,
  input wire bepr_res_s PROT_RES,
  // Password area mirror load
  input wire logic PW_WE,
  input wire logic [3:0] PW_ADDR,
  input wire logic [7:0] PW_WDATA
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  bepr_state_e state_reg, state_next; // Sequence state
  bepr_state_e ret_reg, ret_next; // State after sending
  logic [7:0] tx_reg, tx_next; // Byte being sent
  logic [7:0] tx2_reg, tx2_next; // Queued second byte
  logic tx2_vld_reg, tx2_vld_next; // Second byte pending
  logic [3:0] last_nib_reg, last_nib_next; // Upper nibble of last command
  logic [3:0] idx_reg, idx_next; // Byte counter inside a phase
  logic [7:0] hold_reg, hold_next; // Password byte awaiting compare
  logic [7:0] sum_reg, sum_next; // Running sum of bytes 5..17
  logic rxerr_reg, rxerr_next; // Any receive error in 5..17
  logic miss_reg, miss_next; // Any password mismatch
  logic [7:0] first_reg, first_next; // First stored password byte
  logic same_reg, same_next; // All stored password bytes identical
  logic allff_reg, allff_next; // All stored password bytes blank
  logic vecff_reg, vecff_next; // Reset vector area blank
  logic [3:0] rd_addr; // Mirror read address
  logic [7:0] rd_data; // Mirror read data
  logic rx_take; // Byte accepted this cycle
  logic [3:0] scan_pos; // Index of data now on rd_data during scan
  logic pw_bad; // Password check outcome

  ////////////////////////////////////////////////////////////////////////////
  // Password area mirror
  bepr_pwd_mem #(
    .DEPTH(int'(`BEPR_AREA_LEN)),
    .AW(4)
  ) u_mem (
    .CLK(CLK),
    .we(PW_WE),
    .waddr(PW_ADDR),
    .wdata(PW_WDATA),
    .raddr(rd_addr),
    .rdata(rd_data)
  );

  // Scan walks the area and the password phase follows the byte index: both use idx_reg
  assign rd_addr = idx_reg;
  assign scan_pos = idx_reg - `BEPR_ONE4;

  // Bytes are accepted only where the sequence expects one
  assign RX_READY = (state_reg == ST_CMD) || (state_reg == ST_ERKEY) ||
                    (state_reg == ST_PWD);
  assign rx_take = RX_VALID && RX_READY;
  assign TX_VALID = (state_reg == ST_TX);
  assign TX_DATA = tx_reg;
  assign ERASE_REQ = (state_reg == ST_ERRUN);
  assign PROT_REQ = (state_reg == ST_PRRUN);

  // Uniform stored password fails unless the part is blank
  assign pw_bad = miss_reg || (same_reg && !(allff_reg && vecff_reg));

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic of the sequencer
  always_comb begin
    state_next = state_reg;
    ret_next = ret_reg;
    tx_next = tx_reg;
    tx2_next = tx2_reg;
    tx2_vld_next = tx2_vld_reg;
    last_nib_next = last_nib_reg;
    idx_next = idx_reg;
    hold_next = hold_reg;
    sum_next = sum_reg;
    rxerr_next = rxerr_reg;
    miss_next = miss_reg;
    first_next = first_reg;
    same_next = same_reg;
    allff_next = allff_reg;
    vecff_next = vecff_reg;
    case (state_reg)
      // Operation command byte
      ST_CMD: begin
        if (rx_take) begin
          state_next = ST_TX;
          ret_next = ST_CMD;
          tx2_vld_next = 1'b0;
          if (RX_BYTE.err) begin
            tx_next = {last_nib_reg, `BEPR_NIB_RXERR};
          end else if (RX_BYTE.data == `BEPR_OP_ERASE) begin
            last_nib_next = RX_BYTE.data[7:4];
            tx_next = RX_BYTE.data;
            ret_next = ST_ERKEY;
          end else if (RX_BYTE.data == `BEPR_OP_PROT) begin
            last_nib_next = RX_BYTE.data[7:4];
            tx_next = RX_BYTE.data;
            ret_next = ST_PSCAN;
            idx_next = `BEPR_ZERO4;
          end else begin
            last_nib_next = RX_BYTE.data[7:4];
            tx_next = {RX_BYTE.data[7:4], `BEPR_NIB_CMDERR};
          end
        end
      end
      // Erase enable byte, the fifth of the sequence
      ST_ERKEY: begin
        if (rx_take) begin
          state_next = ST_TX;
          tx2_vld_next = 1'b0;
          ret_next = ST_CMD;
          if (RX_BYTE.err) begin
            tx_next = {last_nib_reg, `BEPR_NIB_RXERR};
          end else if (RX_BYTE.data == `BEPR_ERASE_KEY) begin
            tx_next = RX_BYTE.data;
            ret_next = ST_ERRUN;
          end else begin
            tx_next = {last_nib_reg, `BEPR_NIB_CMDERR};
          end
        end
      end
      // Whole-flash erase in progress
      ST_ERRUN: begin
        if (ERASE_RES.done) begin
          state_next = ST_TX;
          ret_next = ST_CMD;
          tx2_vld_next = 1'b1;
          tx_next = ERASE_RES.fail ? `BEPR_ERASE_BAD : `BEPR_ERASE_OK;
          tx2_next = ERASE_RES.fail ? `BEPR_ERASE_BAD_CNF : `BEPR_ERASE_OK_CNF;
        end
      end
      // Password area check: one read issued per cycle, data one cycle later
      ST_PSCAN: begin
        idx_next = idx_reg + `BEPR_ONE4;
        if (idx_reg == `BEPR_ZERO4) begin
          same_next = 1'b1;
          allff_next = 1'b1;
          vecff_next = 1'b1;
        end else if (scan_pos < `BEPR_PW_LEN) begin
          if (scan_pos == `BEPR_ZERO4) begin
            first_next = rd_data;
          end else if (rd_data != first_reg) begin
            same_next = 1'b0;
          end
          if (rd_data != `BEPR_BLANK) begin
            allff_next = 1'b0;
          end
        end else if (rd_data != `BEPR_BLANK) begin
          vecff_next = 1'b0;
        end
        if (idx_reg == `BEPR_SCAN_END) begin
          state_next = ST_PWD;
          idx_next = `BEPR_ZERO4;
          sum_next = `BEPR_ZERO8;
          rxerr_next = 1'b0;
          miss_next = 1'b0;
        end
      end
      // Password bytes 5..16 and checksum byte 17
      ST_PWD: begin
        if (rx_take) begin
          sum_next = sum_reg + RX_BYTE.data;
          rxerr_next = rxerr_reg | RX_BYTE.err;
          hold_next = RX_BYTE.data;
          state_next = (idx_reg == `BEPR_PW_LEN) ? ST_PSUM : ST_PCMP;
        end
      end
      // Compare held byte against the stored one at the same index
      ST_PCMP: begin
        if (hold_reg != rd_data) begin
          miss_next = 1'b1;
        end
        idx_next = idx_reg + `BEPR_ONE4;
        state_next = ST_PWD;
      end
      // Layered verdict on the eighteenth byte
      ST_PSUM: begin
        state_next = ST_TX;
        tx2_vld_next = 1'b0;
        ret_next = ST_CMD;
        if (rxerr_reg) begin
          tx_next = {last_nib_reg, `BEPR_NIB_RXERR};
        end else if (sum_reg != `BEPR_ZERO8) begin
          tx_next = `BEPR_PROT_CHKERR;
        end else if (pw_bad) begin
          tx_next = `BEPR_PROT_CHKERR;
        end else begin
          tx_next = `BEPR_PROT_ACCEPT;
          ret_next = ST_PRRUN;
        end
      end
      // Protect operation in progress
      ST_PRRUN: begin
        if (PROT_RES.done) begin
          state_next = ST_TX;
          ret_next = ST_CMD;
          tx2_vld_next = 1'b1;
          tx_next = PROT_RES.fail ? `BEPR_PROT_BAD : `BEPR_PROT_OK;
          tx2_next = PROT_RES.fail ? `BEPR_PROT_BAD_CNF : `BEPR_PROT_OK_CNF;
        end
      end
      // Send one byte, then a queued second one, then resume
      ST_TX: begin
        if (TX_READY) begin
          if (tx2_vld_reg) begin
            tx_next = tx2_reg;
            tx2_vld_next = 1'b0;
          end else begin
            state_next = ret_reg;
          end
        end
      end
      default: begin
        state_next = ST_CMD;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg <= ST_CMD;
      ret_reg <= ST_CMD;
      tx_reg <= `BEPR_ZERO8;
      tx2_reg <= `BEPR_ZERO8;
      tx2_vld_reg <= 1'b0;
      last_nib_reg <= `BEPR_ZERO4;
      idx_reg <= `BEPR_ZERO4;
      hold_reg <= `BEPR_ZERO8;
      sum_reg <= `BEPR_ZERO8;
      rxerr_reg <= 1'b0;
      miss_reg <= 1'b0;
      first_reg <= `BEPR_ZERO8;
      same_reg <= 1'b0;
      allff_reg <= 1'b0;
      vecff_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ret_reg <= ret_next;
      tx_reg <= tx_next;
      tx2_reg <= tx2_next;
      tx2_vld_reg <= tx2_vld_next;
      last_nib_reg <= last_nib_next;
      idx_reg <= idx_next;
      hold_reg <= hold_next;
      sum_reg <= sum_next;
      rxerr_reg <= rxerr_next;
      miss_reg <= miss_next;
      first_reg <= first_next;
      same_reg <= same_next;
      allff_reg <= allff_next;
      vecff_reg <= vecff_next;
    end
  end
endmodule // bepr_handler

/* File: testbench/bepr_handler_props.sv */
// Checker of the erase and protect handler ports
module bepr_handler_props import bepr_pkg::*; (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Serial bytes
  input wire logic RX_VALID,
  input wire bepr_rx_s RX_BYTE,
  input wire logic RX_READY,
  input wire logic TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_READY,
  // Engines
  input wire logic ERASE_REQ,
  input wire bepr_res_s ERASE_RES,
  input wire logic PROT_REQ,
  input wire bepr_res_s PROT_RES
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic [7:0] last_reg; // Last byte sent
  logic tk; // Byte taken after erase echo
  logic sent; // Byte sent this edge
  assign sent = TX_VALID && TX_READY;
  assign tk = RX_VALID && RX_READY && last_reg == 8'h40;
  // Remember the last sent byte
  always_ff @(posedge CLK) begin
    if (RST) begin
      last_reg <= 8'h00;
    end else if (sent) begin
      last_reg <= TX_DATA;
    end
  end
  a_reset_idle: assert property ($fell(RST) |-> RX_READY && !TX_VALID
    && !ERASE_REQ) else $error("not idle after reset");
  a_one_way: assert property (RX_READY |-> !TX_VALID && !ERASE_REQ && !PROT_REQ)
    else $error("receive while busy");
  a_tx_stands: assert property (TX_VALID && !TX_READY |=> TX_VALID
    && $stable(TX_DATA)) else $error("byte dropped");
  a_key_echo: assert property (tk && !RX_BYTE.err && RX_BYTE.data == 8'h54
    |=> TX_VALID && TX_DATA == 8'h54) else $error("no key echo");
  a_key_wrong: assert property (tk && !RX_BYTE.err && RX_BYTE.data != 8'h54
    |=> TX_VALID && TX_DATA == 8'h41) else $error("bad key answer");
  a_key_error: assert property (tk && RX_BYTE.err |=> TX_VALID && TX_DATA == 8'h48)
    else $error("key error answer");
  a_erase_start: assert property (sent && TX_DATA == 8'h54 |=> ERASE_REQ)
    else $error("erase not started");
  a_erase_res: assert property (ERASE_REQ && ERASE_RES.done |=> TX_VALID
    && TX_DATA == ($past(ERASE_RES.fail) ? 8'h4C : 8'h4F)) else $error("erase result");
  a_erase_cnf: assert property (sent && (TX_DATA == 8'h4F || TX_DATA == 8'h4C)
    |=> TX_DATA == ($past(TX_DATA) == 8'h4F ? 8'h5D : 8'h60)) else $error("erase cnf");
  a_prot_res: assert property (PROT_REQ && PROT_RES.done |=> TX_VALID
    && TX_DATA == ($past(PROT_RES.fail) ? 8'h6C : 8'h6F)) else $error("protect result");
  a_prot_cnf: assert property (sent && (TX_DATA == 8'h6F || TX_DATA == 8'h6C)
    |=> TX_DATA == ($past(TX_DATA) == 8'h6F ? 8'h31 : 8'h34)) else $error("protect cnf");
  a_next_cmd: assert property (sent && (TX_DATA == 8'h5D
    || TX_DATA == 8'h31) |=> RX_READY) else $error("no new command");
endmodule // bepr_handler_props
bind bepr_handler bepr_handler_props u_props (.CLK, .RST, .RX_VALID, .RX_BYTE, .RX_READY,
  .TX_VALID, .TX_DATA, .TX_READY, .ERASE_REQ, .ERASE_RES, .PROT_REQ, .PROT_RES);

/* File: testbench/bepr_ctrl.sv */
// Programming controller on the serial side
module bepr_ctrl import bepr_pkg::*; (
  // Clock
  input wire logic clk,
  // Bytes to the device
  output logic rx_valid,
  output bepr_rx_s rx_byte,
  input wire logic rx_ready,
  // Bytes from the device
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    rx_valid = 1'b0;
    rx_byte = '0;
    tx_ready = 1'b0;
  end
  // One character with its error flag, held until taken
  task send(input logic [7:0] d, input logic e);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_byte = '{err: e, data: d};
    do @(posedge clk); while (rx_ready !== 1'b1);
    @(negedge clk);
    rx_valid = 1'b0;
    rx_byte.data = ~d; // Released line shows no stale value
  endtask
  // Accept one byte, after slow idle cycles
  task get(output logic [7:0] d, input int slow);
    repeat (slow) @(negedge clk);
    tx_ready = 1'b1;
    do @(posedge clk); while (tx_valid !== 1'b1);
    d = tx_data;
    @(negedge clk);
    tx_ready = 1'b0;
  endtask
endmodule // bepr_ctrl

/* File: testbench/bepr_handler_tb.sv */
// Self-checking bench of the erase and protect handler
module bepr_handler_tb import bepr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK, RST, rx_valid, rx_ready, tx_valid, tx_ready, erase_req, prot_req, pw_we;
  bepr_rx_s rx_byte;
  bepr_res_s erase_res, prot_res;
  logic [7:0] tx_data, pw_wdata;
  logic [3:0] pw_addr;
  logic [7:0] pw [15]; // Mirror image
  int miscompares, samples_checked, cycles;
  bepr_handler uut (.CLK(CLK), .RST(RST), .RX_VALID(rx_valid), .RX_BYTE(rx_byte),
    .RX_READY(rx_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready),
    .ERASE_REQ(erase_req), .ERASE_RES(erase_res), .PROT_REQ(prot_req), .PROT_RES(prot_res),
    .PW_WE(pw_we), .PW_ADDR(pw_addr), .PW_WDATA(pw_wdata));
  bepr_ctrl ctl (.clk(CLK), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  // Hang guard
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Send one byte, take the answer
  task sx(input logic [7:0] d, input logic e, input logic [7:0] exp);
    logic [7:0] r;
    ctl.send(d, e);
    ctl.get(r, 0);
    chk(r, exp);
  endtask
  // Slow read of one byte
  task rd(input logic [7:0] exp);
    logic [7:0] r;
    ctl.get(r, 3);
    chk(r, exp);
  endtask
  // Flash engine: wait request, report done
  task eng(input logic p, input logic f);
    int n;
    n = 0;
    while ((p ? prot_req : erase_req) !== 1'b1 && n < 50) begin
      @(negedge CLK);
      n++;
    end
    chk(8'(n < 50), 8'h01);
    repeat (3) @(negedge CLK);
    if (p) prot_res = '{1'b1, f};
    else erase_res = '{1'b1, f};
    @(negedge CLK);
    prot_res = '0;
    erase_res = '0;
  endtask
  task t_erase(input logic f);
    sx(8'h40, 1'b0, 8'h40);
    sx(8'h54, 1'b0, 8'h54);
    eng(1'b0, f);
    rd(f ? 8'h4C : 8'h4F);
    rd(f ? 8'h60 : 8'h5D);
    $display("erase test done");
  endtask
  task t_bad;
    sx(8'h23, 1'b0, 8'h21);
    sx(8'h60, 1'b1, 8'h28);
    sx(8'h40, 1'b0, 8'h40);
    sx(8'h55, 1'b0, 8'h41);
    sx(8'h40, 1'b0, 8'h40);
    sx(8'h54, 1'b1, 8'h48);
    $display("error test done");
  endtask
  // Load mirror, then one protect session
  task t_prot(input logic [7:0] b, s, v, input int bad, input logic [7:0] ca, input int ei,
    input logic [7:0] exp, input logic f);
    logic [7:0] c, d, r;
    for (int i = 0; i < 15; i++) begin
      pw[i] = i < 12 ? 8'(b + s * i) : v;
      @(negedge CLK);
      pw_we = 1'b1;
      pw_addr = 4'(i);
      pw_wdata = pw[i];
    end
    @(negedge CLK);
    pw_we = 1'b0;
    sx(8'h60, 1'b0, 8'h60);
    c = 8'h00;
    for (int i = 0; i < 13; i++) begin
      d = i == 12 ? 8'(ca - c) : pw[i] ^ 8'(i == bad);
      c += d;
      ctl.send(d, i == ei);
    end
    ctl.get(r, 0);
    chk(r, exp);
    if (exp == 8'h60) begin
      eng(1'b1, f);
      rd(f ? 8'h6C : 8'h6F);
      rd(f ? 8'h34 : 8'h31);
    end else begin
      // A rejected verdict must not start the protect engine
      chk(8'(prot_req), 8'h00);
    end
    $display("protect test done");
  endtask
  initial begin
    RST = 1'b1;
    pw_we = 1'b0;
    pw_addr = 4'h0;
    pw_wdata = 8'h00;
    erase_res = '0;
    prot_res = '0;
    repeat (10) @(negedge CLK);
    RST = 1'b0;
    t_erase(1'b0);
    t_erase(1'b1);
    t_bad();
    t_prot(8'h11, 8'h07, 8'h00, -1, 8'h00, -1, 8'h60, 1'b0);
    t_prot(8'h11, 8'h07, 8'h00, -1, 8'h00, -1, 8'h60, 1'b1);
    t_prot(8'h11, 8'h07, 8'h00, 11, 8'h00, -1, 8'h61, 1'b0);
    t_prot(8'h11, 8'h07, 8'h00, -1, 8'h01, -1, 8'h61, 1'b0);
    t_prot(8'h11, 8'h07, 8'h00, -1, 8'h01, 2, 8'h68, 1'b0);
    t_prot(8'h11, 8'h07, 8'h00, -1, 8'h00, 12, 8'h68, 1'b0);
    t_prot(8'h5A, 8'h00, 8'h00, -1, 8'h00, -1, 8'h61, 1'b0);
    t_prot(8'hFF, 8'h00, 8'h00, -1, 8'h00, -1, 8'h61, 1'b0);
    t_prot(8'hFF, 8'h00, 8'hFF, -1, 8'h00, -1, 8'h60, 1'b0);
    sx(8'h40, 1'b0, 8'h40);
    summarize();
  end
endmodule // bepr_handler_tb
